// ===== card_supply_pkg.sv
package card_supply_pkg;
	// Register word indices; the bus address of each register is its index times four
	localparam logic [15:0] CTRL_IDX = 16'hFE03;
	localparam logic [15:0] TMR_IDX = 16'hFE04;
	localparam logic [15:0] DET_IDX = 16'hFE05;
	localparam logic [15:0] EVT_IDX = 16'hFE01;
	localparam logic [17:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
	localparam logic [17:0] TMR_ADDR = {TMR_IDX, 2'b00};
	localparam logic [17:0] DET_ADDR = {DET_IDX, 2'b00};
	localparam logic [17:0] EVT_ADDR = {EVT_IDX, 2'b00};
	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] TMR_RESET = 8'h0F;
	localparam logic [7:0] DET_RESET = 8'h00;
	// Control field positions
	localparam int SEL_HI = 7;
	localparam int SEL_LO = 6;
	localparam int FAULT_BIT = 5;
	localparam int READY_START_BIT = 4;
	localparam int GOOD_BIT = 3;
	localparam int POWEROFF_BIT = 0;
	// Timer field positions
	localparam int OFFD_HI = 7;
	localparam int OFFD_LO = 4;
	localparam int CHK_HI = 3;
	localparam int CHK_LO = 0;
	// Detect control positions
	localparam int DEB_BIT = 7;
	localparam int DETEN_BIT = 6;
	localparam int POL_BIT = 3;
	localparam int PUN_BIT = 2;
	localparam int PD_BIT = 1;
	localparam int CARDIN_BIT = 0;
	localparam logic [7:0] DET_WMASK = 8'hCE;
	// Event status positions
	localparam int EVT_CARD_BIT = 6;
	localparam int EVT_TMR_BIT = 5;
	// Slow tick: 32768 Hz period from the 20 MHz core clock
	localparam int CLK_HZ = 20000000;
	localparam int SLOW_HZ = 32768;
	localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
	localparam logic [9:0] SLOW_LAST = 10'(SLOW_DIV - 1);
	// Debounce: 64 ms of stable detect
	localparam int DEB_MS = 64;
	localparam int DEB_CYCLES = CLK_HZ / 1000 * DEB_MS;
	localparam logic [3:0] NIBBLE_ZERO = 4'h0;
	localparam logic [1:0] SEL_OFF = 2'h0;
	// Sequencer states
	typedef enum logic [2:0] {S_OFF, S_CHECK, S_WAITRDY, S_ON, S_OFFDLY} seq_state_t;
	// Avalon-MM request
	typedef struct packed {
		logic [17:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} avm_req_t;
	// Avalon-MM answer
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} avm_rsp_t;
	// Companion pins
	typedef struct packed {
		logic cmdLow_n;
		logic cmdHigh_n;
		logic coreOff;
	} supply_pins_t;
endpackage

// ===== card_supply_sequencer.sv
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
// Notes on behaviour
// - Non-zero voltage select write starts activation
// - Select chooses 5V, 3V or 1.8V
// - Fault-handling 0: core fault forces commands high
// - Ready-start set: activation waits for supply-good
// - Ready-start clear: timer expiry starts deactivation
// - Supply-good status readable at bit 3
// - Power-off bit shuts core supply down
// - Bus power present defers power-off
// - Supply not good at expiry: event, deactivate
// - Check interval is field times 32768Hz period
// - Off-delay field delays normal deactivation
// - Off-delay zero adds no delay
// - Emergency deactivation skips the off-delay
// - Detection runs without smart card clock
// - Power-down flag: detect works, no debounce
// - Card event flag on insert/remove/fault
// - Supply timer flag on every check-interval timeout, not on off-delay expiry
module card_supply_sequencer #(
	// Voltage code per level
	parameter logic [1:0] CODE_5V = 2'h1,
	parameter logic [1:0] CODE_3V = 2'h2,
	parameter logic [1:0] CODE_1V8 = 2'h3
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Avalon-MM slave
	input wire card_supply_pkg::avm_req_t avReq,
	output card_supply_pkg::avm_rsp_t avRsp,
	// Pins from outside
	input wire logic supplyGoodPin,
	input wire logic companionReady,
	input wire logic coreFault,
	input wire logic busPower,
	input wire logic interfaceFault,
	input wire logic card_detect_pin,
	input wire logic power_down_flag,
	// Pins to companion and power control
	output card_supply_pkg::supply_pins_t supplyPins,
	output logic [2:0] voltageOneHot,
	output logic pullUpEnable_n,
	output logic pullDownEnable
);
	// Synchronised inputs: stage one only feeds stage two
	logic [6:0] syncA_q, syncB_q;
	logic goodS, readyS, faultS, busS, ifFaultS, detS, pdS;
	assign {goodS, readyS, faultS, busS, ifFaultS, detS, pdS} = syncB_q;

	// All state except the input synchronisers in one struct
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] tmr;
		logic [7:0] det;
		logic cardEvt;
		logic tmrEvt;
		logic [3:0] count;
		card_supply_pkg::seq_state_t st;
		logic presPrev;
		logic ifPrev;
		logic faultPrev;
		logic offPending;
		card_supply_pkg::supply_pins_t pins;
		logic [2:0] volt;
		logic [31:0] rdata;
		logic ack;
		logic waitReq; // Own flop, so the bus pin needs no inverter
		logic puN;
		logic pd;
	} seq_q_t;
	seq_q_t s_q, s_d;

	logic tick, present;
	logic wrCtrl, wrTmr, wrDet, rdEvt;
	logic [1:0] selNew;
	logic timeout, firstCycle;

	// Decode helper shared by every access
	function automatic logic hit(input card_supply_pkg::avm_req_t r, input logic [17:0] a);
		hit = (r.address == a);
	endfunction

	// Voltage code to one-hot level {1.8V, 3V, 5V}
	function automatic logic [2:0] levelOf(input logic [1:0] code);
		levelOf = 3'h0;
		if (code == CODE_5V) levelOf = 3'h1;
		if (code == CODE_3V) levelOf = 3'h2;
		if (code == CODE_1V8) levelOf = 3'h4;
	endfunction

	// Slow timebase
	slow_tick tickGen (
		.core_clk(core_clk),
		.reset(reset),
		.tick(tick)
	);

	// Detection is core-clocked, so it never depends on the card clock
	detect_filter detector (
		.core_clk(core_clk),
		.reset(reset),
		.enable(s_q.det[card_supply_pkg::DETEN_BIT]),
		.polarity(s_q.det[card_supply_pkg::POL_BIT]),
		.debounce(s_q.det[card_supply_pkg::DEB_BIT] & ~pdS),
		.pinLevel(detS),
		.present(present)
	);

	// Writes land at the edge where waitrequest is seen low, one access per two cycles
	// Reads snapshot and clear the flags at the request's first edge, one edge before the taken edge, so a later event waits
	assign firstCycle = (avReq.read | avReq.write) & ~s_q.ack;
	assign wrCtrl = s_q.ack & avReq.write & hit(avReq, card_supply_pkg::CTRL_ADDR);
	assign wrTmr = s_q.ack & avReq.write & hit(avReq, card_supply_pkg::TMR_ADDR);
	assign wrDet = s_q.ack & avReq.write & hit(avReq, card_supply_pkg::DET_ADDR);
	assign rdEvt = firstCycle & avReq.read & hit(avReq, card_supply_pkg::EVT_ADDR);
	assign selNew = avReq.writedata[card_supply_pkg::SEL_HI:card_supply_pkg::SEL_LO];
	// Expiry on the tick that would bring the count to zero
	assign timeout = tick && (s_q.count == 4'h1);

	// Next-state logic
	always_comb begin
		logic [1:0] sel;
		logic coreFaultEdge;
		logic cardEdge;
		logic emergency;
		logic setCard;
		logic setTmr;
		sel = s_q.ctrl[card_supply_pkg::SEL_HI:card_supply_pkg::SEL_LO];
		s_d = s_q;
		coreFaultEdge = faultS & ~s_q.faultPrev;
		cardEdge = (present != s_q.presPrev) | (ifFaultS & ~s_q.ifPrev);
		emergency = 1'b0;
		setCard = cardEdge;
		setTmr = 1'b0;
		s_d.faultPrev = faultS;
		s_d.presPrev = present;
		s_d.ifPrev = ifFaultS;
		s_d.ack = firstCycle;
		s_d.waitReq = ~firstCycle;
		// Register writes
		if (wrCtrl) begin
			s_d.ctrl[card_supply_pkg::SEL_HI:card_supply_pkg::SEL_LO] = selNew;
			s_d.ctrl[card_supply_pkg::FAULT_BIT] = avReq.writedata[card_supply_pkg::FAULT_BIT];
			s_d.ctrl[card_supply_pkg::READY_START_BIT] = avReq.writedata[card_supply_pkg::READY_START_BIT];
			s_d.ctrl[card_supply_pkg::POWEROFF_BIT] = avReq.writedata[card_supply_pkg::POWEROFF_BIT];
		end
		if (wrTmr) begin
			s_d.tmr = avReq.writedata[7:0];
		end
		if (wrDet) begin
			s_d.det = (avReq.writedata[7:0] & card_supply_pkg::DET_WMASK);
		end
		// Sequencer
		case (s_q.st)
			card_supply_pkg::S_OFF: begin
				if (wrCtrl && selNew != card_supply_pkg::SEL_OFF) begin
					s_d.count = s_q.tmr[card_supply_pkg::CHK_HI:card_supply_pkg::CHK_LO];
					if (s_q.tmr[card_supply_pkg::CHK_HI:card_supply_pkg::CHK_LO] == card_supply_pkg::NIBBLE_ZERO)
						s_d.st = card_supply_pkg::S_WAITRDY;
					else
						s_d.st = card_supply_pkg::S_CHECK;
				end
			end
			card_supply_pkg::S_CHECK: begin
				// Flag every expiry, even when an earlier branch below wins
				setTmr = timeout;
				if (sel == card_supply_pkg::SEL_OFF) begin
					s_d.st = card_supply_pkg::S_OFF;
				end else if (s_q.ctrl[card_supply_pkg::READY_START_BIT] && goodS) begin
					s_d.st = card_supply_pkg::S_ON;
				end else if (timeout) begin
					setTmr = 1'b1;
					if (!goodS) begin
						setCard = 1'b1;
						emergency = 1'b1;
					end else if (!s_q.ctrl[card_supply_pkg::READY_START_BIT]) begin
						emergency = 1'b1;
					end else begin
						s_d.st = card_supply_pkg::S_ON;
					end
				end else if (tick) begin
					s_d.count = s_q.count - 4'h1;
				end
			end
			card_supply_pkg::S_WAITRDY: begin
				if (sel == card_supply_pkg::SEL_OFF) begin
					s_d.st = card_supply_pkg::S_OFF;
				end else if (s_q.ctrl[card_supply_pkg::READY_START_BIT] && readyS && goodS) begin
					s_d.st = card_supply_pkg::S_ON;
				end
			end
			card_supply_pkg::S_ON: begin
				if (sel == card_supply_pkg::SEL_OFF) begin
					s_d.count = s_q.tmr[card_supply_pkg::OFFD_HI:card_supply_pkg::OFFD_LO];
					if (s_q.tmr[card_supply_pkg::OFFD_HI:card_supply_pkg::OFFD_LO] == card_supply_pkg::NIBBLE_ZERO)
						s_d.st = card_supply_pkg::S_OFF;
					else
						s_d.st = card_supply_pkg::S_OFFDLY;
				end
			end
			card_supply_pkg::S_OFFDLY: begin
				if (timeout) s_d.st = card_supply_pkg::S_OFF;
				else if (tick) s_d.count = s_q.count - 4'h1;
			end
			default: s_d.st = card_supply_pkg::S_OFF;
		endcase
		// Card event while powered is an emergency
		if (cardEdge && s_q.st != card_supply_pkg::S_OFF) emergency = 1'b1;
		// Core fault with hardware handling
		if (coreFaultEdge && !s_q.ctrl[card_supply_pkg::FAULT_BIT]) emergency = 1'b1;
		if (emergency) begin
			s_d.st = card_supply_pkg::S_OFF;
			s_d.ctrl[card_supply_pkg::SEL_HI:card_supply_pkg::SEL_LO] = card_supply_pkg::SEL_OFF;
		end
		// Event flags: set wins over read-clear
		if (rdEvt) begin
			s_d.cardEvt = 1'b0;
			s_d.tmrEvt = 1'b0;
		end
		if (setCard) s_d.cardEvt = 1'b1;
		if (setTmr) s_d.tmrEvt = 1'b1;
		// Companion commands: active low, held on only while sequencer powers the card
		s_d.pins.cmdLow_n = 1'b1;
		s_d.pins.cmdHigh_n = 1'b1;
		s_d.volt = 3'h0;
		if (!emergency && s_d.st != card_supply_pkg::S_OFF && !(faultS && !s_q.ctrl[card_supply_pkg::FAULT_BIT])) begin
			// Off-delay keeps the last level, since select is already zero then
			if (s_d.ctrl[card_supply_pkg::SEL_HI:card_supply_pkg::SEL_LO] == card_supply_pkg::SEL_OFF) begin
				s_d.volt = s_q.volt;
			end else begin
				s_d.volt = levelOf(s_d.ctrl[card_supply_pkg::SEL_HI:card_supply_pkg::SEL_LO]);
			end
			// One command per level: 5V on the high command, 3V and 1.8V on the low one
			s_d.pins.cmdHigh_n = ~s_d.volt[0];
			s_d.pins.cmdLow_n = ~(s_d.volt[1] | s_d.volt[2]);
		end
		// Firmware-run fault path simply clears select, which drops commands above once any programmed off-delay has run
		// Power-off held until bus power goes away
		s_d.offPending = s_d.ctrl[card_supply_pkg::POWEROFF_BIT];
		s_d.pins.coreOff = s_q.offPending & ~busS;
		// Status and read data
		s_d.ctrl[card_supply_pkg::GOOD_BIT] = goodS;
		s_d.det[card_supply_pkg::CARDIN_BIT] = present;
		s_d.puN = ~s_d.det[card_supply_pkg::PUN_BIT];
		s_d.pd = s_d.det[card_supply_pkg::PD_BIT];
		// Read data registered, so it stands at the acknowledging edge
		s_d.rdata = 32'h00000000;
		if (firstCycle && avReq.read) begin
			if (hit(avReq, card_supply_pkg::CTRL_ADDR)) s_d.rdata = {24'h000000, s_q.ctrl};
			if (hit(avReq, card_supply_pkg::TMR_ADDR)) s_d.rdata = {24'h000000, s_q.tmr};
			if (hit(avReq, card_supply_pkg::DET_ADDR)) s_d.rdata = {24'h000000, s_q.det};
			if (rdEvt) s_d.rdata = {24'h000000, 1'b0, s_q.cardEvt, s_q.tmrEvt, 5'h00};
		end
	end

	// Registers
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_q <= '0;
			s_q.ctrl <= card_supply_pkg::CTRL_RESET;
			s_q.tmr <= card_supply_pkg::TMR_RESET;
			s_q.det <= card_supply_pkg::DET_RESET;
			s_q.pins <= 3'b110;
			s_q.puN <= 1'b1;
			s_q.waitReq <= 1'b1;
			syncA_q <= '0;
			syncB_q <= '0;
		end else begin
			s_q <= s_d;
			syncA_q <= {supplyGoodPin, companionReady, coreFault, busPower, interfaceFault, card_detect_pin,
				power_down_flag};
			syncB_q <= syncA_q;
		end
	end

	// Outputs from flip-flops
	assign supplyPins = s_q.pins;
	assign voltageOneHot = s_q.volt;
	assign pullUpEnable_n = s_q.puN;
	assign pullDownEnable = s_q.pd;
	assign avRsp.readdata = s_q.rdata;
	assign avRsp.waitrequest = s_q.waitReq;

	// Checks
	// Antecedents leave out emergencies where another rule takes over
	fault_cmd_a: assert property (@(posedge core_clk) disable iff (reset)
		(faultS && !s_q.ctrl[card_supply_pkg::FAULT_BIT]) |=> (supplyPins.cmdLow_n && supplyPins.cmdHigh_n))
		else $error("core fault did not drop commands");
	bus_defer_a: assert property (@(posedge core_clk) disable iff (reset)
		busS |=> !supplyPins.coreOff)
		else $error("power-off not deferred by bus power");
	timer_flag_a: assert property (@(posedge core_clk) disable iff (reset)
		(s_q.st == card_supply_pkg::S_CHECK && timeout && s_q.ctrl[7:6] != 2'h0) |=> s_q.tmrEvt)
		else $error("timer flag not set");
	bad_supply_a: assert property (@(posedge core_clk) disable iff (reset)
		(s_q.st == card_supply_pkg::S_CHECK && timeout && !goodS && s_q.ctrl[7:6] != 2'h0)
		|=> (s_q.cardEvt && s_q.st == card_supply_pkg::S_OFF && s_q.ctrl[7:6] == 2'h0))
		else $error("bad supply not handled");
	start_a: assert property (@(posedge core_clk) disable iff (reset)
		(s_q.st == card_supply_pkg::S_OFF && wrCtrl && selNew != 2'h0 && !faultS && !(present ^ s_q.presPrev)
		&& !ifFaultS) |=> s_q.st != card_supply_pkg::S_OFF)
		else $error("activation did not start");
	offdelay_a: assert property (@(posedge core_clk) disable iff (reset)
		(s_q.st == card_supply_pkg::S_ON && s_q.ctrl[7:6] == 2'h0 && s_q.tmr[7:4] != 4'h0 && !faultS
		&& present == s_q.presPrev && !(ifFaultS && !s_q.ifPrev)) |=> s_q.st == card_supply_pkg::S_OFFDLY)
		else $error("off delay skipped");
	ack_a: assert property (@(posedge core_clk) disable iff (reset)
		(avReq.read || avReq.write) && avRsp.waitrequest |=> !avRsp.waitrequest)
		else $error("bus answer late");
	good_bit_a: assert property (@(posedge core_clk) disable iff (reset)
		s_q.ctrl[card_supply_pkg::GOOD_BIT] == $past(goodS))
		else $error("supply-good status stale");
	cmd_pair_a: assert property (@(posedge core_clk) disable iff (reset)
		!(!supplyPins.cmdLow_n && !supplyPins.cmdHigh_n))
		else $error("both companion commands low");
	delay_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		(s_q.st == card_supply_pkg::S_OFFDLY && !faultS && !$past(faultS)) |-> voltageOneHot != 3'h0)
		else $error("supply dropped during off delay");
	no_delay_a: assert property (@(posedge core_clk) disable iff (reset)
		(s_q.st == card_supply_pkg::S_ON
		&& s_q.ctrl[card_supply_pkg::SEL_HI:card_supply_pkg::SEL_LO] == card_supply_pkg::SEL_OFF
		&& s_q.tmr[card_supply_pkg::OFFD_HI:card_supply_pkg::OFFD_LO] == card_supply_pkg::NIBBLE_ZERO)
		|=> s_q.st == card_supply_pkg::S_OFF)
		else $error("zero off delay still delayed");
	skip_delay_a: assert property (@(posedge core_clk) disable iff (reset)
		(s_q.st != card_supply_pkg::S_OFF && $rose(faultS) && !s_q.ctrl[card_supply_pkg::FAULT_BIT])
		|=> (s_q.st == card_supply_pkg::S_OFF && supplyPins.cmdLow_n && supplyPins.cmdHigh_n))
		else $error("fault deactivation waited");
	card_flag_a: assert property (@(posedge core_clk) disable iff (reset)
		(present != s_q.presPrev) |=> s_q.cardEvt)
		else $error("card event flag missed");
	core_off_a: assert property (@(posedge core_clk) disable iff (reset)
		(s_q.offPending && !busS) |=> supplyPins.coreOff)
		else $error("power-off not applied");
	ready_wait_a: assert property (@(posedge core_clk) disable iff (reset)
		(s_q.st == card_supply_pkg::S_WAITRDY && !readyS) |=> s_q.st != card_supply_pkg::S_ON)
		else $error("powered without companion ready");
	wait_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
		!avRsp.waitrequest |=> avRsp.waitrequest)
		else $error("bus answer held too long");
endmodule

// ===== companion_model.sv
`timescale 1ns/1ps
// Companion supply circuit: ramps the card supply while either command is low
module companion_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Commands from the sequencer
	input wire logic cmdLow_n,
	input wire logic cmdHigh_n,
	// Behaviour settings from the bench
	input wire logic [15:0] riseDelay,
	input wire logic neverGood,
	// Status back to the sequencer
	output logic supplyGood,
	output logic ready
);
	logic [15:0] rampCount; // Cycles since the supply was commanded on

	// Supply ramps only while commanded; both commands high removes it at once
	always_ff @(posedge core_clk) begin
		if (reset || (cmdLow_n && cmdHigh_n)) begin
			rampCount <= 16'h0000;
			supplyGood <= 1'b0;
			ready <= 1'b0;
		end else begin
			if (rampCount != 16'hFFFF) begin
				rampCount <= rampCount + 16'h0001;
			end
			// A dead supply never reports good, so the timeout path is exercised
			supplyGood <= !neverGood && (rampCount >= riseDelay);
			ready <= !neverGood && (rampCount >= riseDelay);
		end
	end
endmodule

// ===== detect_filter.sv
`timescale 1ns/1ps
// Card presence with optional debounce; assertion waits, release is immediate
module detect_filter (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Settings
	input wire logic enable,
	input wire logic polarity,
	input wire logic debounce,
	// Synchronised pin level
	input wire logic pinLevel,
	// Presence
	output logic present
);
	// State
	typedef struct packed {
		logic [20:0] cnt;
		logic present;
	} det_state_t;
	det_state_t s_q, s_d;
	logic raw;

	// Polarity: 1 means high pin is a card
	assign raw = enable & (polarity ? pinLevel : ~pinLevel);

	// Debounce counter
	always_comb begin
		s_d = s_q;
		if (!raw) begin
			s_d.cnt = '0;
			s_d.present = 1'b0;
		end else if (!debounce) begin
			s_d.present = 1'b1;
		end else if (s_q.cnt == 21'(card_supply_pkg::DEB_CYCLES - 1)) begin
			s_d.present = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 21'h000001;
		end
	end

	// Register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign present = s_q.present;
endmodule

// ===== slow_tick.sv
`timescale 1ns/1ps
// One-cycle pulse every 32768 Hz period
module slow_tick (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Tick out
	output logic tick
);
	// State: divider count and tick flag
	typedef struct packed {
		logic [9:0] cnt;
		logic tick;
	} tick_state_t;
	tick_state_t s_q, s_d;

	// Next state
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.cnt == card_supply_pkg::SLOW_LAST) begin
			s_d.cnt = 10'h000;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 10'h001;
		end
	end

	// Register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign tick = s_q.tick;
endmodule

// ===== test_card_supply_sequencer.sv
`timescale 1ns/1ps
// Self-checking bench for the card supply sequencer
module test_card_supply_sequencer;
	logic core_clk = 1'b0; // 20 MHz
	logic reset = 1'b1; // Held for three cycles
	card_supply_pkg::avm_req_t avReq = '0; // Bus request
	card_supply_pkg::avm_rsp_t avRsp; // Bus answer
	logic supplyGoodPin;
	logic companionReady;
	logic coreFault = 1'b0;
	logic busPower = 1'b0;
	logic card_detect_pin = 1'b0;
	logic power_down_flag = 1'b0;
	logic interfaceFault = 1'b0; // Companion fault report
	card_supply_pkg::supply_pins_t supplyPins;
	logic [2:0] voltageOneHot;
	logic pullUpEnable_n;
	logic pullDownEnable;
	logic [15:0] riseDelay = 16'h0004; // Companion ramp time in cycles
	logic neverGood = 1'b0; // Companion supply never settles
	int bad_count = 0;
	int check_count = 0;
	int cycleCount = 0;
	int n; // Cycles measured by waitOff
	logic [31:0] rd; // Last read data
	wire logic cmdsOff = supplyPins.cmdLow_n & supplyPins.cmdHigh_n;

	// Free-running clock
	always #25 core_clk = ~core_clk;

	card_supply_sequencer DUT (.core_clk(core_clk), .reset(reset), .avReq(avReq), .avRsp(avRsp),
		.supplyGoodPin(supplyGoodPin), .companionReady(companionReady), .coreFault(coreFault),
		.busPower(busPower), .interfaceFault(interfaceFault), .card_detect_pin(card_detect_pin),
		.power_down_flag(power_down_flag), .supplyPins(supplyPins), .voltageOneHot(voltageOneHot),
		.pullUpEnable_n(pullUpEnable_n), .pullDownEnable(pullDownEnable));

	companion_model partner (.core_clk(core_clk), .reset(reset), .cmdLow_n(supplyPins.cmdLow_n),
		.cmdHigh_n(supplyPins.cmdHigh_n), .riseDelay(riseDelay), .neverGood(neverGood),
		.supplyGood(supplyGoodPin), .ready(companionReady));

	// Counts, verdict and end of run
	task report_and_stop;
		$display("Checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge core_clk) begin
		cycleCount++;
		if (cycleCount == 60000) begin
			bad_count++;
			report_and_stop();
		end
	end

	// Compare one value
	task check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bus write; request held until waitrequest is seen low at an edge
	task busWrite(input logic [17:0] a, input logic [7:0] d);
		avReq.address <= a;
		avReq.writedata <= {24'h000000, d};
		avReq.write <= 1'b1;
		do @(posedge core_clk); while (avRsp.waitrequest !== 1'b0);
		avReq.write <= 1'b0;
		// Idle edge so a following call never reassigns the strobe in one step
		@(posedge core_clk);
	endtask

	// Bus read; data taken at the acknowledging edge
	task busRead(input logic [17:0] a, output logic [31:0] d);
		avReq.address <= a;
		avReq.read <= 1'b1;
		do @(posedge core_clk); while (avRsp.waitrequest !== 1'b0);
		d = avRsp.readdata;
		avReq.read <= 1'b0;
		@(posedge core_clk);
	endtask

	// Cycles until cmdsOff reaches the wanted value, bounded
	task waitOff(input logic want, output int cnt);
		cnt = 0;
		while (cmdsOff !== want && cnt < 5000) begin
			@(posedge core_clk);
			cnt++;
		end
	endtask

	// Reset values and an unmapped address
	task test_reset_values;
		busRead(card_supply_pkg::CTRL_ADDR, rd); check(rd, 32'h00000000);
		busRead(card_supply_pkg::TMR_ADDR, rd); check(rd, 32'h0000000F);
		busRead(card_supply_pkg::DET_ADDR, rd); check(rd, 32'h00000000);
		busWrite(18'h00010, 8'hFF);
		busRead(18'h00010, rd); check(rd, 32'h00000000);
		busRead(card_supply_pkg::CTRL_ADDR, rd); check(rd, 32'h00000000);
	endtask

	// Every select code, ready-start with the timeout disabled
	task test_codes;
		busWrite(card_supply_pkg::TMR_ADDR, 8'h00);
		for (int c = 1; c < 4; c++) begin
			busWrite(card_supply_pkg::CTRL_ADDR, {2'(c), 6'h10});
			waitOff(1'b0, n);
			check(32'(n < 20), 32'h1);
			repeat (12) @(posedge core_clk);
			check(32'(voltageOneHot), 32'(3'b001 << (c - 1)));
			check(32'({supplyPins.cmdLow_n, supplyPins.cmdHigh_n}), (c == 1) ? 32'h2 : 32'h1);
			busRead(card_supply_pkg::CTRL_ADDR, rd); check(rd, 32'({2'(c), 6'h18}));
			repeat (1900) @(posedge core_clk);
			check(32'(cmdsOff), 32'h0);
			busWrite(card_supply_pkg::CTRL_ADDR, 8'h10);
			waitOff(1'b1, n);
			check(32'(n < 20), 32'h1);
		end
	endtask

	// Supply never good: timeout clears select and raises both flags
	task test_check_fail;
		neverGood <= 1'b1;
		busWrite(card_supply_pkg::TMR_ADDR, 8'h02);
		busWrite(card_supply_pkg::CTRL_ADDR, 8'h40);
		waitOff(1'b0, n);
		waitOff(1'b1, n);
		check(32'(n >= 600 && n <= 1300), 32'h1);
		busRead(card_supply_pkg::CTRL_ADDR, rd); check(rd, 32'h00000000);
		busRead(card_supply_pkg::EVT_ADDR, rd); check(rd, 32'h00000060);
		busRead(card_supply_pkg::EVT_ADDR, rd); check(rd, 32'h00000000);
		neverGood <= 1'b0;
	endtask

	// Ready-start clear: expiry deactivates even with a good supply
	task test_ready_start_clear;
		busWrite(card_supply_pkg::CTRL_ADDR, 8'h40);
		waitOff(1'b0, n);
		waitOff(1'b1, n);
		check(32'(n >= 600 && n <= 1300), 32'h1);
		busRead(card_supply_pkg::EVT_ADDR, rd); check(rd & 32'h20, 32'h00000020);
	endtask

	// Normal deactivation waits the programmed off-delay
	task test_off_delay;
		busWrite(card_supply_pkg::TMR_ADDR, 8'h30);
		busWrite(card_supply_pkg::CTRL_ADDR, 8'h50);
		waitOff(1'b0, n);
		repeat (20) @(posedge core_clk);
		busWrite(card_supply_pkg::CTRL_ADDR, 8'h10);
		waitOff(1'b1, n);
		check(32'(n >= 1200 && n <= 1900), 32'h1);
	endtask

	// Core fault with hardware handling, then with firmware handling
	task test_core_fault;
		busWrite(card_supply_pkg::TMR_ADDR, 8'hF0);
		busWrite(card_supply_pkg::CTRL_ADDR, 8'h50);
		waitOff(1'b0, n);
		repeat (20) @(posedge core_clk);
		coreFault <= 1'b1;
		waitOff(1'b1, n);
		check(32'(n <= 10), 32'h1);
		coreFault <= 1'b0;
		busWrite(card_supply_pkg::CTRL_ADDR, 8'h00);
		busWrite(card_supply_pkg::TMR_ADDR, 8'h00);
		busWrite(card_supply_pkg::CTRL_ADDR, 8'h70);
		waitOff(1'b0, n);
		repeat (20) @(posedge core_clk);
		coreFault <= 1'b1;
		repeat (20) @(posedge core_clk);
		check(32'(cmdsOff), 32'h0);
		busWrite(card_supply_pkg::CTRL_ADDR, 8'h30);
		waitOff(1'b1, n);
		check(32'(n <= 20), 32'h1);
		coreFault <= 1'b0;
	endtask

	// Detect in power-down: no debounce, events on insert and removal
	task test_detect;
		power_down_flag <= 1'b1;
		busWrite(card_supply_pkg::DET_ADDR, 8'h8A);
		busWrite(card_supply_pkg::DET_ADDR, 8'hCA);
		busRead(card_supply_pkg::EVT_ADDR, rd);
		card_detect_pin <= 1'b1;
		repeat (10) @(posedge core_clk);
		busRead(card_supply_pkg::DET_ADDR, rd); check(rd, 32'h000000CB);
		check(32'({pullUpEnable_n, pullDownEnable}), 32'h3);
		busRead(card_supply_pkg::EVT_ADDR, rd); check(rd & 32'h40, 32'h00000040);
		card_detect_pin <= 1'b0;
		repeat (10) @(posedge core_clk);
		busRead(card_supply_pkg::DET_ADDR, rd); check(rd, 32'h000000CA);
		busRead(card_supply_pkg::EVT_ADDR, rd); check(rd & 32'h40, 32'h00000040);
		// Interface fault from the companion is a card event too
		interfaceFault <= 1'b1;
		repeat (6) @(posedge core_clk);
		busRead(card_supply_pkg::EVT_ADDR, rd);
		check(rd & 32'h40, 32'h00000040);
		interfaceFault <= 1'b0;
	endtask

	// Power-off deferred while bus power is present
	task test_power_off;
		busPower <= 1'b1;
		busWrite(card_supply_pkg::CTRL_ADDR, 8'h01);
		repeat (20) @(posedge core_clk);
		check(32'(supplyPins.coreOff), 32'h0);
		busPower <= 1'b0;
		repeat (10) @(posedge core_clk);
		check(32'(supplyPins.coreOff), 32'h1);
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		test_reset_values();
		test_codes();
		test_check_fail();
		test_ready_start_clear();
		test_off_delay();
		test_core_fault();
		test_detect();
		test_power_off();
		report_and_stop();
	end
endmodule
